// [hw/clm_action_applier.sv]
`timescale 1ns/1ps
module clm_action_applier
	import clm_pkg::*;
#(
	parameter int GIDX_W = 12
)
(
	input  wire logic                     clk_i,
	input  wire logic                     sys_rst_i,
	input  wire logic                     sof_i,
	input  wire logic [7:0]               init_policy_group_i,
	input  wire logic [6:0]               init_port_i,
	input  wire logic [GIDX_W-1:0]        init_svc_index_i,
	input  wire clm_pkg::frame_layer_t    init_layer_i,
	input  wire logic [clm_pkg::PTR_W-1:0] init_ptr_i,
	input  wire logic [clm_pkg::PTR_W-1:0] rsv_lbl_bytes_i,
	input  wire logic [clm_pkg::PTR_W-1:0] eth_len_i,
	input  wire logic [clm_pkg::PTR_W-1:0] ip_len_i,
	input  wire logic                     ip_vld_i,
	input  wire logic                     terminated_i,
	input  wire logic                     act_vld_i,
	input  wire logic                     act_short_i,
	input  wire logic                     mep_ena_i,
	input  wire logic                     mip_ena_i,
	input  wire logic                     mpls_oam_variant_i,
	input  wire logic [2:0]               mpls_control_channel_sel_i,
	input  wire logic [4:0]               custom_rule_key_enables_i,
	input  wire logic [1:0]               custom_extract_point_i,
	input  wire logic [7:0]               policy_group_override_mask_i,
	input  wire logic [7:0]               policy_group_value_i,
	input  wire logic                     acl_key_select_override_i,
	input  wire logic [5:0]               acl_key_select_i,
	input  wire logic                     masquerade_enable_i,
	input  wire logic [6:0]               masquerade_port_i,
	input  wire logic                     logical_port_override_i,
	input  wire logic [6:0]               logical_port_value_i,
	input  wire logic [15:0]              match_tag_i,
	input  wire logic [15:0]              match_tag_mask_i,
	input  wire logic [1:0]               pipeline_force_code_i,
	input  wire logic                     pipeline_action_variant_i,
	input  wire logic [4:0]               pipeline_point_i,
	input  wire logic [2:0]               pipeline_point_short_i,
	input  wire logic [4:0]               next_key_format_i,
	input  wire logic [1:0]               next_quad_byte_offset_i,
	input  wire logic [4:0]               next_double_byte_offset_i,
	input  wire clm_pkg::layer_skip_t     next_layer_skip_i,
	input  wire clm_pkg::frame_layer_t    next_frame_layer_i,
	input  wire logic                     next_strip_enable_i,
	input  wire clm_pkg::gidx_ctrl_t      next_group_index_ctrl_i,
	input  wire logic [GIDX_W-1:0]        next_group_index_i,
	output logic                          chan_type_chk_o,
	output logic                          mip_sw_extract_o,
	output logic [2:0]                    oam_channel_o,
	output logic                          custom_key_sel_o,
	output logic [3:0]                    custom_lookup_ena_o,
	output logic [clm_pkg::PTR_W-1:0]     custom_data_ofs_o,
	output logic [7:0]                    policy_association_group_o,
	output logic [5:0]                    acl_key_select_o,
	output logic                          acl_key_forced_o,
	output logic [6:0]                    ingress_port_o,
	output logic                          learn_dis_o,
	output logic [6:0]                    logical_port_o,
	output logic [6:0]                    header_source_port_o,
	output logic [15:0]                   header_class_result_o,
	output logic [4:0]                    pipeline_point_o,
	output clm_pkg::pipe_act_t            pipeline_action_o,
	output logic [4:0]                    key_format_o,
	output logic                          norm_dst_key_o,
	output logic                          lookups_done_o,
	output logic [clm_pkg::PTR_W-1:0]     frame_ptr_o,
	output clm_pkg::frame_layer_t         frame_layer_o,
	output logic                          strip_ena_o,
	output logic                          strip_over_o,
	output logic [GIDX_W-1:0]             group_index_key_o,
	output logic [GIDX_W-1:0]             ingress_service_index_o
);
	import clm_pkg::*;

	typedef struct packed {
		logic                 chk;
		logic                 mip;
		logic [2:0]           chan;
		logic                 ckey;
		logic [3:0]           clook;
		logic [PTR_W-1:0]     cofs;
		logic [7:0]           pgrp;
		logic [5:0]           aks;
		logic                 akf;
		logic [6:0]           iport;
		logic                 nolearn;
		logic [6:0]           lgport;
		logic [6:0]           sport;
		logic [15:0]          mtag;
		logic [4:0]           ppt;
		pipe_act_t            pact;
		logic [4:0]           kfmt;
		logic                 done;
		logic [PTR_W-1:0]     ptr;
		frame_layer_t         layer;
		logic                 strip;
		logic                 sover;
		logic [GIDX_W-1:0]    gidx;
		logic [GIDX_W-1:0]    svc;
	} cls_state_t;

	cls_state_t st_ff;
	cls_state_t nxt_st;
	logic       act_ok;
	logic       nonterm;

	frame_ptr_if fp ();

	frame_ptr_calc u_ptr
	(
		.fp (fp)
	);

	// Reserved labels are skipped before the action, so offsets start past them
	assign fp.cur_ptr   = PTR_W'(st_ff.ptr + rsv_lbl_bytes_i);
	assign fp.cur_layer = st_ff.layer;
	assign fp.skip      = next_layer_skip_i;
	assign fp.quad_ofs  = act_short_i ? next_quad_byte_offset_i : 2'h0;
	assign fp.dbl_ofs   = act_short_i ? 5'h00 : next_double_byte_offset_i;
	assign fp.eth_len   = eth_len_i;
	assign fp.ip_len    = ip_len_i;
	assign fp.ip_vld    = ip_vld_i;

	// Once lookups are complete, later records for the frame are ignored
	assign act_ok  = act_vld_i && !sof_i && !st_ff.done;
	assign nonterm = !terminated_i;

	always_comb
	begin
		nxt_st = st_ff;
		if (sof_i)
		begin
			nxt_st       = '0;
			nxt_st.pgrp   = init_policy_group_i;
			nxt_st.iport  = init_port_i;
			nxt_st.lgport = init_port_i;
			nxt_st.sport  = init_port_i;
			nxt_st.svc    = init_svc_index_i;
			nxt_st.layer = init_layer_i;
			nxt_st.ptr   = init_ptr_i;
			nxt_st.pact  = PACT_NONE;
		end
		else if (act_ok)
		begin
			nxt_st.chan = mpls_control_channel_sel_i;
			nxt_st.chk  = mep_ena_i && !mpls_oam_variant_i;
			nxt_st.mip  = mip_ena_i;
			if (!act_short_i)
			begin
				nxt_st.ckey  = custom_rule_key_enables_i[0];
				nxt_st.clook = custom_rule_key_enables_i[4:1];
				unique case (custom_extract_point_i)
					2'h0: nxt_st.cofs = st_ff.ptr;
					2'h1: nxt_st.cofs = eth_len_i;
					2'h2: nxt_st.cofs = PTR_W'(eth_len_i + EXTRACT_OFS_20);
					2'h3: nxt_st.cofs = PTR_W'(eth_len_i + EXTRACT_OFS_40);
				endcase
				nxt_st.mtag = mask_merge(st_ff.mtag, match_tag_i, match_tag_mask_i);
			end
			nxt_st.pgrp = 8'(mask_merge({8'h00, st_ff.pgrp}, {8'h00, policy_group_value_i},
				{8'h00, policy_group_override_mask_i}));
			if (acl_key_select_override_i)
			begin
				nxt_st.aks = acl_key_select_i;
				nxt_st.akf = 1'b1;
			end
			if (masquerade_enable_i)
			begin
				nxt_st.iport   = masquerade_port_i;
				nxt_st.nolearn = 1'b1;
				nxt_st.pact    = PACT_INJ_MASQ;
			end
			if (logical_port_override_i)
			begin
				nxt_st.lgport = logical_port_value_i;
				nxt_st.sport = logical_port_value_i;
			end
			// Forcing comes after masquerade so an explicit force has the last word
			if (pipeline_force_code_i != 2'h0)
			begin
				nxt_st.ppt = act_short_i ? short_point(pipeline_point_short_i)
					: pipeline_point_i;
				unique case (pipeline_force_code_i)
					2'h1: nxt_st.pact = PACT_XTR;
					2'h2: nxt_st.pact = pipeline_action_variant_i ? PACT_INJ_MASQ : PACT_INJ;
					2'h3: nxt_st.pact = pipeline_action_variant_i ? PACT_LBK_ASM : PACT_LBK_QS;
					2'h0: nxt_st.pact = st_ff.pact;
				endcase
			end
			nxt_st.kfmt = next_key_format_i;
			nxt_st.done = (next_key_format_i == KEY_FMT_DONE);
			nxt_st.ptr  = fp.new_ptr;
			if (fp.moved || (st_ff.layer == LAYER_DATA && next_key_format_i != KEY_FMT_DEFAULT))
				nxt_st.layer = next_frame_layer_i;
			// Strip length is the pointer after this action's own move
			if (next_strip_enable_i)
			begin
				nxt_st.strip = 1'b1;
				nxt_st.sover = (fp.new_ptr > STRIP_MAX_BYTES);
			end
			unique case (next_group_index_ctrl_i)
				GIDX_KEEP:    nxt_st.gidx = st_ff.gidx;
				GIDX_REPLACE: nxt_st.gidx = next_group_index_i;
				GIDX_ADD:     nxt_st.gidx = GIDX_W'(st_ff.gidx + next_group_index_i);
				GIDX_SVC:     nxt_st.gidx = st_ff.svc;
				GIDX_RPL_COND:
				begin
					nxt_st.gidx = next_group_index_i;
					if (terminated_i)
						nxt_st.svc = next_group_index_i;
				end
				GIDX_SVC_NT:  nxt_st.gidx = nonterm ? st_ff.svc : next_group_index_i;
				GIDX_RPL_SVC:
				begin
					nxt_st.svc = next_group_index_i;
					if (nonterm)
						nxt_st.gidx = next_group_index_i;
				end
				default:      nxt_st.gidx = st_ff.gidx;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign chan_type_chk_o           = st_ff.chk;
	assign mip_sw_extract_o          = st_ff.mip;
	assign oam_channel_o             = st_ff.chan;
	assign custom_key_sel_o          = st_ff.ckey;
	assign custom_lookup_ena_o       = st_ff.clook;
	assign custom_data_ofs_o         = st_ff.cofs;
	assign policy_association_group_o = st_ff.pgrp;
	assign acl_key_select_o          = st_ff.aks;
	assign acl_key_forced_o          = st_ff.akf;
	assign ingress_port_o            = st_ff.iport;
	assign learn_dis_o               = st_ff.nolearn;
	assign logical_port_o            = st_ff.lgport;
	assign header_source_port_o      = st_ff.sport;
	assign header_class_result_o     = st_ff.mtag;
	assign pipeline_point_o          = st_ff.ppt;
	assign pipeline_action_o         = st_ff.pact;
	assign key_format_o              = st_ff.kfmt;
	assign norm_dst_key_o            = (st_ff.kfmt == KEY_FMT_NORM_DST);
	assign lookups_done_o            = st_ff.done;
	assign frame_ptr_o               = st_ff.ptr;
	assign frame_layer_o             = st_ff.layer;
	assign strip_ena_o               = st_ff.strip;
	assign strip_over_o              = st_ff.sover;
	assign group_index_key_o         = st_ff.gidx;
	assign ingress_service_index_o   = st_ff.svc;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	group_merge_a: assert property (act_ok |=> policy_association_group_o ==
		(($past(policy_association_group_o) & ~$past(policy_group_override_mask_i))
		| ($past(policy_group_value_i) & $past(policy_group_override_mask_i))))
		else $error("policy group merge wrong");
	mep_check_a: assert property (act_ok && mep_ena_i |=>
		chan_type_chk_o == !$past(mpls_oam_variant_i))
		else $error("channel type check wrong");
	masq_port_a: assert property (act_ok && masquerade_enable_i
		&& pipeline_force_code_i == 2'h0
		|=> ingress_port_o == $past(masquerade_port_i) && learn_dis_o
		&& pipeline_action_o == PACT_INJ_MASQ)
		else $error("masquerade not applied");
	port_ovr_a: assert property (act_ok && logical_port_override_i |=>
		logical_port_o == $past(logical_port_value_i) && header_source_port_o == logical_port_o)
		else $error("logical port not replaced");
	force_xtr_a: assert property (act_ok && pipeline_force_code_i == 2'h1
		&& !act_short_i
		|=> pipeline_action_o == PACT_XTR && pipeline_point_o == $past(pipeline_point_i))
		else $error("forced extraction wrong");
	no_force_a: assert property (act_ok && pipeline_force_code_i == 2'h0
		&& !masquerade_enable_i |=> $stable(pipeline_action_o) && $stable(pipeline_point_o))
		else $error("pipeline changed without force");
	done_hold_a: assert property (lookups_done_o && !sof_i |=> $stable(frame_ptr_o)
		&& $stable(policy_association_group_o) && lookups_done_o)
		else $error("action applied after lookups done");
	layer_keep_a: assert property (act_ok && !fp.moved
		&& st_ff.layer != LAYER_DATA |=> $stable(frame_layer_o))
		else $error("layer changed without move");
	gidx_add_a: assert property (act_ok && next_group_index_ctrl_i == GIDX_ADD |=>
		group_index_key_o == GIDX_W'($past(group_index_key_o) + $past(next_group_index_i)))
		else $error("group index add wrong");
	quad_move_a: assert property (act_ok && act_short_i
		&& next_layer_skip_i == SKIP_NONE
		|=> frame_ptr_o == PTR_W'($past(frame_ptr_o) + $past(rsv_lbl_bytes_i)
		+ {$past(next_quad_byte_offset_i), 2'b00}))
		else $error("quad offset move wrong");

	masq_cov: cover property (act_ok && masquerade_enable_i);
	done_cov: cover property (act_ok && next_key_format_i == KEY_FMT_DONE);
	strip_cov: cover property (act_ok && next_strip_enable_i && next_layer_skip_i == SKIP_IP);
	rpl_cov: cover property (act_ok && next_group_index_ctrl_i == GIDX_RPL_SVC);
endmodule : clm_action_applier

// [hw/clm_pkg.sv]
package clm_pkg;
	localparam int PTR_W = 8;

	// Channel type that MEP detection compares against when the variant is 0
	localparam logic [15:0] MEP_CHAN_TYPE = 16'h8902;

	localparam logic [7:0] STRIP_MAX_BYTES = 8'h2a;
	localparam logic [7:0] QUAD_UNIT_SHIFT = 8'h02;
	localparam logic [7:0] DBL_UNIT_SHIFT  = 8'h01;
	localparam logic [7:0] EXTRACT_OFS_20  = 8'h14;
	localparam logic [7:0] EXTRACT_OFS_40  = 8'h28;

	localparam logic [4:0] KEY_FMT_DEFAULT  = 5'h00;
	localparam logic [4:0] KEY_FMT_NORM_DST = 5'h08;
	localparam logic [4:0] KEY_FMT_DONE     = 5'h11;

	localparam logic [4:0] PT_NONE       = 5'h00;
	localparam logic [4:0] PT_PORT_VOE   = 5'h02;
	localparam logic [4:0] PT_CLM        = 5'h04;
	localparam logic [4:0] PT_OU_MIP     = 5'h06;
	localparam logic [4:0] PT_OU_VOE     = 5'h09;
	localparam logic [4:0] PT_IN_VOE     = 5'h0b;
	localparam logic [4:0] PT_IN_MIP     = 5'h0e;
	localparam logic [4:0] PT_DONE       = 5'h10;
	localparam logic [4:0] PT_REW_IN_VOE = 5'h11;
	localparam logic [4:0] PT_REW_OU_VOE = 5'h12;

	typedef enum logic [2:0] {
		PACT_NONE     = 3'b000,
		PACT_XTR      = 3'b001,
		PACT_INJ      = 3'b010,
		PACT_INJ_MASQ = 3'b011,
		PACT_LBK_QS   = 3'b100,
		PACT_LBK_ASM  = 3'b101
	} pipe_act_t;

	typedef enum logic [1:0] {
		LAYER_ETH  = 2'b00,
		LAYER_CW   = 2'b01,
		LAYER_MPLS = 2'b10,
		LAYER_DATA = 2'b11
	} frame_layer_t;

	typedef enum logic [1:0] {
		SKIP_NONE = 2'b00,
		SKIP_ETH  = 2'b01,
		SKIP_IP   = 2'b10,
		SKIP_RSV  = 2'b11
	} layer_skip_t;

	typedef enum logic [2:0] {
		GIDX_KEEP      = 3'b000,
		GIDX_REPLACE   = 3'b001,
		GIDX_ADD       = 3'b010,
		GIDX_SVC       = 3'b011,
		GIDX_RPL_COND  = 3'b100,
		GIDX_SVC_NT    = 3'b101,
		GIDX_RPL_SVC   = 3'b110,
		GIDX_UNUSED    = 3'b111
	} gidx_ctrl_t;

	function automatic logic [4:0] short_point(input logic [2:0] code);
		logic [4:0] pt;
		unique case (code)
			3'h0: pt = PT_CLM;
			3'h1: pt = PT_OU_MIP;
			3'h2: pt = PT_IN_MIP;
			3'h3: pt = PT_PORT_VOE;
			3'h4: pt = PT_OU_VOE;
			3'h5: pt = PT_IN_VOE;
			3'h6: pt = PT_REW_IN_VOE;
			3'h7: pt = PT_REW_OU_VOE;
		endcase
		return pt;
	endfunction : short_point

	function automatic logic [15:0] mask_merge(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic [15:0] mask);
		return (old_v & ~mask) | (new_v & mask);
	endfunction : mask_merge
endpackage : clm_pkg

// [hw/frame_ptr_if.sv]
`timescale 1ns/1ps
interface frame_ptr_if;
	import clm_pkg::*;
	logic [PTR_W-1:0] cur_ptr;
	frame_layer_t     cur_layer;
	layer_skip_t      skip;
	logic [1:0]       quad_ofs;
	logic [4:0]       dbl_ofs;
	logic [PTR_W-1:0] eth_len;
	logic [PTR_W-1:0] ip_len;
	logic             ip_vld;
	logic [PTR_W-1:0] new_ptr;
	logic             moved;

	modport calc (input cur_ptr, cur_layer, skip, quad_ofs, dbl_ofs, eth_len, ip_len, ip_vld,
		output new_ptr, moved);
	modport user (output cur_ptr, cur_layer, skip, quad_ofs, dbl_ofs, eth_len, ip_len, ip_vld,
		input new_ptr, moved);
endinterface : frame_ptr_if

// [hw/frame_ptr_calc.sv]
`timescale 1ns/1ps
module frame_ptr_calc
(
	frame_ptr_if.calc fp
);
	import clm_pkg::*;

	logic [PTR_W-1:0] skipped;
	logic [PTR_W-1:0] ofs_bytes;

	// Layer skip is resolved first, word offsets are added on top of it
	always_comb
	begin
		skipped = fp.cur_ptr;
		unique case (fp.skip)
			SKIP_ETH:
			begin
				if (fp.cur_layer == LAYER_ETH)
					skipped = PTR_W'(fp.cur_ptr + fp.eth_len);
			end
			SKIP_IP:
			begin
				if (fp.cur_layer == LAYER_ETH && fp.ip_vld)
					skipped = PTR_W'(fp.cur_ptr + fp.eth_len + fp.ip_len);
				else if (fp.cur_layer == LAYER_CW && fp.ip_vld)
					skipped = PTR_W'(fp.cur_ptr + fp.ip_len);
			end
			SKIP_NONE, SKIP_RSV: skipped = fp.cur_ptr;
		endcase
		// Units of four and two bytes
		ofs_bytes = PTR_W'({6'h00, fp.quad_ofs} << QUAD_UNIT_SHIFT)
			+ PTR_W'({3'h0, fp.dbl_ofs} << DBL_UNIT_SHIFT);
		fp.new_ptr = PTR_W'(skipped + ofs_bytes);
		fp.moved = (fp.new_ptr != fp.cur_ptr);
	end
endmodule : frame_ptr_calc

// [verif/frame_ctx_model.sv]
`timescale 1ns/1ps
module frame_ctx_model
(
	input  wire logic                      clk_i,
	input  wire logic                      sof_i,
	output logic [clm_pkg::PTR_W-1:0]      eth_len_o,
	output logic [clm_pkg::PTR_W-1:0]      ip_len_o,
	output logic                           ip_vld_o,
	output logic [clm_pkg::PTR_W-1:0]      rsv_lbl_bytes_o,
	output logic                           terminated_o
);
	initial
	begin
		eth_len_o = 8'h0e;
		ip_len_o = 8'h14;
		ip_vld_o = 1'b1;
		rsv_lbl_bytes_o = 8'h00;
		terminated_o = 1'b0;
	end
	// Header facts change only at frame start, as a real parser reports them
	always @(posedge clk_i)
	begin
		if (sof_i)
		begin
			eth_len_o <= 8'(8'h0e + 4 * $urandom_range(0, 3));
			ip_len_o <= 8'(8'h14 + 4 * $urandom_range(0, 4));
			rsv_lbl_bytes_o <= 8'(4 * $urandom_range(0, 1));
			ip_vld_o <= 1'($urandom);
			terminated_o <= 1'($urandom);
		end
	end
endmodule : frame_ctx_model

// [verif/clm_action_applier_tb.sv]
`timescale 1ns/1ps
module clm_action_applier_tb;
	import clm_pkg::*;
	logic clk_i, sys_rst_i, sof_i, ip_vld_i, terminated_i, act_vld_i, act_short_i, mep_ena_i;
	logic mip_ena_i, mpls_oam_variant_i, acl_key_select_override_i, masquerade_enable_i;
	logic logical_port_override_i, pipeline_action_variant_i, next_strip_enable_i;
	logic [2:0] mpls_control_channel_sel_i, pipeline_point_short_i, oam_channel_o;
	logic [4:0] custom_rule_key_enables_i, pipeline_point_i, next_key_format_i;
	logic [4:0] next_double_byte_offset_i, pipeline_point_o, key_format_o;
	logic [1:0] custom_extract_point_i, pipeline_force_code_i, next_quad_byte_offset_i;
	logic [7:0] init_policy_group_i, policy_group_override_mask_i, policy_group_value_i;
	logic [6:0] init_port_i, masquerade_port_i, logical_port_value_i;
	logic [5:0] acl_key_select_i, acl_key_select_o;
	logic [15:0] match_tag_i, match_tag_mask_i, header_class_result_o;
	logic [11:0] init_svc_index_i, next_group_index_i, group_index_key_o, ingress_service_index_o;
	logic [PTR_W-1:0] init_ptr_i, rsv_lbl_bytes_i, eth_len_i, ip_len_i;
	frame_layer_t init_layer_i, next_frame_layer_i, frame_layer_o, lay_e;
	layer_skip_t next_layer_skip_i;
	gidx_ctrl_t next_group_index_ctrl_i;
	logic chan_type_chk_o, mip_sw_extract_o, custom_key_sel_o, acl_key_forced_o, learn_dis_o;
	logic norm_dst_key_o, lookups_done_o, strip_ena_o, strip_over_o;
	logic [3:0] custom_lookup_ena_o, lk_e;
	logic [PTR_W-1:0] custom_data_ofs_o, frame_ptr_o, cofs_e, ptr_e;
	logic [7:0] policy_association_group_o, grp_e;
	logic [6:0] ingress_port_o, logical_port_o, header_source_port_o, inp_e, lp_e;
	pipe_act_t pipeline_action_o, pa_e;
	logic chk_e, mip_e, ksel_e, aclf_e, lrn_e, str_e, sov_e;
	logic [2:0] ch_e;
	logic [5:0] acl_e;
	logic [15:0] cls_e;
	logic [4:0] pt_e, kf_e;
	logic [11:0] gix_e, svc_e;
	logic started = 1'b0;
	int failures = 0;
	int cmp_count = 0;
	localparam logic [4:0] SHORT_PT [8] = '{PT_CLM, PT_OU_MIP, PT_IN_MIP, PT_PORT_VOE,
		PT_OU_VOE, PT_IN_VOE, PT_REW_IN_VOE, PT_REW_OU_VOE};

	clm_action_applier i_clm_action_applier (.*);
	frame_ctx_model i_frame_ctx_model (.clk_i(clk_i), .sof_i(sof_i), .eth_len_o(eth_len_i),
		.ip_len_o(ip_len_i), .ip_vld_o(ip_vld_i), .rsv_lbl_bytes_o(rsv_lbl_bytes_i),
		.terminated_o(terminated_i));

	always #25 clk_i = ~clk_i;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic clear_exp();
		{chk_e, mip_e, ksel_e, aclf_e, lrn_e, str_e, sov_e, ch_e, lk_e, cofs_e, ptr_e} = '0;
		{grp_e, acl_e, inp_e, lp_e, cls_e, pt_e, kf_e, gix_e, svc_e} = '0;
		pa_e = PACT_NONE;
		lay_e = LAYER_ETH;
	endtask : clear_exp

	task automatic apply();
		logic [PTR_W-1:0] p, p0;
		p0 = ptr_e;
		p = ptr_e + rsv_lbl_bytes_i;
		if (next_layer_skip_i == SKIP_ETH && lay_e == LAYER_ETH) p = p + eth_len_i;
		if (next_layer_skip_i == SKIP_IP && ip_vld_i && lay_e == LAYER_ETH)
			p = p + eth_len_i + ip_len_i;
		if (next_layer_skip_i == SKIP_IP && ip_vld_i && lay_e == LAYER_CW) p = p + ip_len_i;
		p = p + (act_short_i ? 8'(4 * next_quad_byte_offset_i) : 8'(2 * next_double_byte_offset_i));
		if (p != 8'(ptr_e + rsv_lbl_bytes_i) || (lay_e == LAYER_DATA && next_key_format_i != 0))
			lay_e = next_frame_layer_i;
		ptr_e = p;
		// Strip request stays for the frame; its length is judged when it is asked
		if (next_strip_enable_i) {str_e, sov_e} = {1'b1, p > STRIP_MAX_BYTES};
		chk_e = mep_ena_i && !mpls_oam_variant_i;
		mip_e = mip_ena_i;
		ch_e = mpls_control_channel_sel_i;
		if (!act_short_i)
		begin
			ksel_e = custom_rule_key_enables_i[0];
			lk_e = custom_rule_key_enables_i[4:1];
			cofs_e = (custom_extract_point_i == 2'h0) ? p0
				: eth_len_i + 8'(20 * (custom_extract_point_i - 1));
			cls_e = (cls_e & ~match_tag_mask_i) | (match_tag_i & match_tag_mask_i);
		end
		grp_e = (grp_e & ~policy_group_override_mask_i) |
			(policy_group_value_i & policy_group_override_mask_i);
		if (acl_key_select_override_i) {aclf_e, acl_e} = {1'b1, acl_key_select_i};
		if (masquerade_enable_i) {lrn_e, inp_e, pa_e} = {1'b1, masquerade_port_i, PACT_INJ_MASQ};
		if (logical_port_override_i) lp_e = logical_port_value_i;
		if (pipeline_force_code_i != 0)
		begin
			pt_e = act_short_i ? SHORT_PT[pipeline_point_short_i] : pipeline_point_i;
			pa_e = pipe_act_t'({pipeline_force_code_i, pipeline_action_variant_i} - 3'h2);
			if (pipeline_force_code_i == 2'h1) pa_e = PACT_XTR;
		end
		kf_e = next_key_format_i;
		case (next_group_index_ctrl_i)
			GIDX_REPLACE: gix_e = next_group_index_i;
			GIDX_ADD: gix_e = gix_e + next_group_index_i;
			GIDX_SVC: gix_e = svc_e;
			GIDX_RPL_COND: {gix_e, svc_e} = {next_group_index_i,
				terminated_i ? next_group_index_i : svc_e};
			GIDX_SVC_NT: gix_e = terminated_i ? next_group_index_i : svc_e;
			GIDX_RPL_SVC: {gix_e, svc_e} = {terminated_i ? gix_e : next_group_index_i,
				next_group_index_i};
			default: ;
		endcase
	endtask : apply

	task automatic drive(input logic s, input logic a);
		logic sh;
		sh = 1'($urandom);
		{sof_i, act_vld_i, act_short_i} <= {s, a, sh};
		{init_policy_group_i, init_port_i, init_svc_index_i} <= 27'($urandom);
		init_layer_i <= frame_layer_t'($urandom_range(0, 3));
		init_ptr_i <= 8'($urandom_range(0, 15));
		{mep_ena_i, mip_ena_i, mpls_oam_variant_i, mpls_control_channel_sel_i} <= 6'($urandom);
		{custom_rule_key_enables_i, pipeline_force_code_i, pipeline_action_variant_i} <= 8'($urandom);
		custom_extract_point_i <= 2'($urandom);
		policy_group_override_mask_i <= sh ? 8'h00 : 8'($urandom);
		{policy_group_value_i, acl_key_select_i, masquerade_port_i} <= 21'($urandom);
		acl_key_select_override_i <= !sh && $urandom_range(0, 1) == 1;
		masquerade_enable_i <= !sh && $urandom_range(0, 3) == 0;
		logical_port_override_i <= !sh && $urandom_range(0, 1) == 1;
		{logical_port_value_i, match_tag_i} <= 23'($urandom);
		{match_tag_mask_i, pipeline_point_short_i, next_quad_byte_offset_i} <= 21'($urandom);
		pipeline_point_i <= 5'($urandom_range(0, 16));
		next_key_format_i <= 5'($urandom_range(0, 17));
		next_double_byte_offset_i <= 5'($urandom_range(0, 15));
		next_layer_skip_i <= layer_skip_t'($urandom_range(0, 3));
		next_frame_layer_i <= frame_layer_t'($urandom_range(0, 3));
		next_group_index_ctrl_i <= gidx_ctrl_t'($urandom_range(0, 7));
		{next_strip_enable_i, next_group_index_i} <= 13'($urandom);
	endtask : drive

	task automatic step(input logic s, input logic a);
		@(posedge clk_i);
		if (sys_rst_i || sof_i) clear_exp();
		if (!sys_rst_i && sof_i)
		begin
			{grp_e, inp_e, lp_e, svc_e} = {init_policy_group_i, init_port_i, init_port_i,
				init_svc_index_i};
			{lay_e, ptr_e} = {init_layer_i, init_ptr_i};
		end
		else if (!sys_rst_i && act_vld_i && kf_e != KEY_FMT_DONE) apply();
		started = 1'b1;
		drive(s, a);
	endtask : step

	always @(negedge clk_i)
	begin
		if (started)
		begin
			check(chan_type_chk_o, chk_e, "chk");
			check({mip_sw_extract_o, oam_channel_o}, {mip_e, ch_e}, "mip");
			check({custom_key_sel_o, custom_lookup_ena_o}, {ksel_e, lk_e}, "cust");
			check(custom_data_ofs_o, cofs_e, "cofs");
			check(policy_association_group_o, grp_e, "group");
			check({acl_key_forced_o, acl_key_select_o}, {aclf_e, acl_e}, "acl");
			check({learn_dis_o, ingress_port_o}, {lrn_e, inp_e}, "masq");
			check({logical_port_o, header_source_port_o}, {lp_e, lp_e}, "logical_port");
			check(header_class_result_o, cls_e, "cls");
			check({pipeline_point_o, pipeline_action_o}, {pt_e, pa_e}, "pipe");
			check({key_format_o, lookups_done_o}, {kf_e, kf_e == KEY_FMT_DONE}, "kf");
			check(norm_dst_key_o, kf_e == KEY_FMT_NORM_DST, "ndst");
			check(frame_ptr_o, ptr_e, "ptr");
			check(frame_layer_o, lay_e, "layer");
			check({strip_ena_o, strip_over_o}, {str_e, sov_e}, "strip");
			check({group_index_key_o, ingress_service_index_o}, {gix_e, svc_e}, "gidx");
		end
	end

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict

	initial
	begin
		clk_i = 1'b0;
		sys_rst_i = 1'b1;
		void'($urandom(34688));
		drive(1'b0, 1'b0);
		step(1'b0, 1'b0);
		step(1'b0, 1'b0);
		sys_rst_i <= 1'b0;
		for (int f = 0; f < 500; f++)
		begin
			// A mid-run reset must drop all state, not just the frame's
			if (f == 250)
			begin
				sys_rst_i <= 1'b1;
				step(1'b0, 1'b1);
				step(1'b0, 1'b0);
				sys_rst_i <= 1'b0;
			end
			step(1'b1, 1'($urandom_range(0, 3) == 0));
			repeat ($urandom_range(1, 6)) step(1'b0, 1'($urandom_range(0, 3) != 0));
		end
		step(1'b0, 1'b0);
		step(1'b0, 1'b0);
		print_verdict();
	end
endmodule : clm_action_applier_tb
